/* File: rtl/tmr_defs.vh */
/*
 * tmr_defs.vh: register offsets, field positions, reset values and
 * mode codes of the timer channel.
 * Assumes byte addressing on a 32-bit Wishbone bus.
 */
`ifndef TMR_DEFS_VH
`define TMR_DEFS_VH

// register byte offsets
`define TMR_OFF_CTRL 8'h08
`define TMR_OFF_MODE 8'h0c
`define TMR_OFF_CNT 8'h1c
`define TMR_OFF_CMP0 8'h20
`define TMR_OFF_CMP1 8'h24
`define TMR_OFF_CAP0 8'h28
`define TMR_OFF_CAP1 8'h2c

// control register fields
`define TMR_CR_START 0
`define TMR_CR_TRIG 1
`define TMR_CR_RSV3_2 3:2
`define TMR_CR_SYNC 5
`define TMR_CR_RSV6 6
`define TMR_CR_DBUF 7
`define TMR_CR_RESET 8'h00

// mode register fields
`define TMR_MD_CLK 2:0
`define TMR_MD_CLE 3
`define TMR_MD_SWCAP 6
`define TMR_MD_RSV7 7
`define TMR_MD_CPM 10:8
`define TMR_MD_LO_RESET 8'h00
`define TMR_MD_CPM_RESET 3'h0

// capture/clear mode codes
`define TMR_CPM_OFF 3'h0
`define TMR_CPM_IN0_IN1 3'h1
`define TMR_CPM_IN0_BOTH 3'h2
`define TMR_CPM_FF 3'h3
`define TMR_CPM_CLR1 3'h4
`define TMR_CPM_CAP0_CLR1 3'h5

// source clock codes
`define TMR_CLK_PIN 3'h0
`define TMR_CLK_D1 3'h1
`define TMR_CLK_D4 3'h2
`define TMR_CLK_D16 3'h3
`define TMR_CLK_BLANK 3'h4
`define TMR_CLK_D64 3'h5
`define TMR_CLK_D128 3'h6
`define TMR_CLK_D256 3'h7

// prescaler tap indices (divide by 2 to the index)
`define TMR_TAP_D1 0
`define TMR_TAP_D4 2
`define TMR_TAP_D16 4
`define TMR_TAP_D64 6
`define TMR_TAP_D128 7
`define TMR_TAP_D256 8

`define TMR_CNT_ZERO 16'h0000

`endif

/* File: rtl/tmr_sync_edge.v */
/*
 * tmr_sync_edge.v: two-stage synchroniser with rise and fall pulses.
 * Assumes an asynchronous pin input and one clock.
 */
`timescale 1ns/1ns
`default_nettype none
module tmr_sync_edge (
    // clock and reset
    input wire clk,
    input wire rst,
    // pin
    input wire pinIn,
    // synchronised level and edges
    output wire level,
    output wire rise,
    output wire fall
);
    reg meta_ff;
    reg sync_ff;
    reg prev_ff;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= pinIn;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign level = sync_ff;
    assign rise = sync_ff & ~prev_ff;
    assign fall = ~sync_ff & prev_ff;
endmodule // tmr_sync_edge
`default_nettype wire

/* File: rtl/tmr_prescaler.v */
/*
 * tmr_prescaler.v: free divider giving one-cycle tap enables.
 * Assumes tap k pulses once every 2**k cycles while enabled.
 */
`timescale 1ns/1ns
`default_nettype none
module tmr_prescaler #(
    parameter WIDTH = 8
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // control
    input wire enable,
    // tap enables, tap 0 every cycle
    output wire [WIDTH:0] tap
);
    reg [WIDTH-1:0] div_ff;
    genvar k;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
            div_ff <= {WIDTH{1'b0}};
        else if (!enable)
            div_ff <= {WIDTH{1'b0}};
        else
            div_ff <= div_ff + {{(WIDTH-1){1'b0}}, 1'b1};
    end

    assign tap[0] = enable;
    generate
        for (k = 1; k <= WIDTH; k = k + 1)
        begin : g_tap
            assign tap[k] = enable & (&div_ff[k-1:0]);
        end
    endgenerate
endmodule // tmr_prescaler
`default_nettype wire

/* File: rtl/tmr_timer_channel.v */
/*
 * tmr_timer_channel.v: one 16-bit up-counting timer channel with its
 * control and mode registers, compare and capture registers, on a
 * classic Wishbone slave.
 * Assumes run command, sync start pulse and flip-flop level come from
 * logic on clk; trigger, count and capture inputs are asynchronous pins.
 */
// Functional notes
// - start source bit: 0 software run, 1 wait for external trigger edge
// - trigger edge bit: 0 rising, 1 falling edge of trigger input
// - sync bit: 0 start alone, 1 start with other channels
// - capture/clear mode 000 disables all pin capture and clear
// - mode 001: input0 rise to capture0, input1 rise to capture1
// - mode 010: input0 rise to capture0, input0 fall to capture1
// - mode 011: flip-flop rise to capture0, fall to capture1
// - mode 100: no capture, input1 rise clears counter
// - mode 101: input0 rise to capture0, input1 rise clears counter
// - capture stores the count before a simultaneous clear
// - writing 0 to bit 6 captures into capture0; reads as 1
// - clear enable bit lets compare1 match clear the counter
// - source clock 000 counts rising edges of the external count pin
// - codes 001..111 pick divide 1,4,16,64,128,256; 100 counts nothing
// - counter is 16-bit, counting up from zero per source tick
// - both compare registers have buffer and active stages
`timescale 1ns/1ns
`default_nettype none
`include "tmr_defs.vh"
module tmr_timer_channel #(
    parameter CW = 16,
    parameter PRE_W = 8
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output wire wb_ack_o,
    // channel control from neighbouring logic
    input wire runCmd,
    input wire syncStart,
    input wire timerFlipflopOutput,
    // pins
    input wire externalCountInput,
    input wire captureInput0,
    input wire captureInput1,
    // events and state
    output reg [CW-1:0] countValue,
    output reg compareMatch0,
    output reg compareMatch1,
    output reg overflowEvent,
    output reg capture0Event,
    output reg capture1Event,
    output wire counting
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_WAIT = 3'b010;
    localparam [2:0] ST_RUN = 3'b100;

    reg ack_ff;
    reg [7:0] ctrl_ff;
    reg [7:0] modeLo_ff;
    reg [2:0] cpm_ff;
    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [CW-1:0] cnt_ff;
    reg [CW-1:0] nxt_cnt;
    reg [CW-1:0] cmpBuf0_ff;
    reg [CW-1:0] cmpBuf1_ff;
    reg [CW-1:0] cmpAct0_ff;
    reg [CW-1:0] cmpAct1_ff;
    reg [CW-1:0] cap0_ff;
    reg [CW-1:0] cap1_ff;
    reg ffPrev_ff;
    reg tick;
    reg cap0Go;
    reg cap1Go;
    reg pinClear;
    reg trigGo;
    reg startGo;

    wire access;
    wire wrEn;
    wire swCapture;
    wire [PRE_W:0] tap;
    wire in0Rise;
    wire in0Fall;
    wire in1Rise;
    wire trigRise;
    wire trigFall;
    wire cntRise;
    wire ffRise;
    wire ffFall;
    wire match0;
    wire match1;
    wire cmpClear;
    wire dbufEn;

    // synchronised pin edges
    tmr_sync_edge u_in0 (
        .clk(clk),
        .rst(rst),
        .pinIn(captureInput0),
        .level(),
        .rise(in0Rise),
        .fall(in0Fall)
    );

    tmr_sync_edge u_in1 (
        .clk(clk),
        .rst(rst),
        .pinIn(captureInput1),
        .level(),
        .rise(in1Rise),
        .fall()
    );

    // count pin doubles as the start trigger
    tmr_sync_edge u_cin (
        .clk(clk),
        .rst(rst),
        .pinIn(externalCountInput),
        .level(),
        .rise(trigRise),
        .fall(trigFall)
    );

    assign cntRise = trigRise;

    tmr_prescaler #(
        .WIDTH(PRE_W)
    ) u_pre (
        .clk(clk),
        .rst(rst),
        .enable(runCmd),
        .tap(tap)
    );

    // flip-flop level is on clk, edge detect only
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            ffPrev_ff <= 1'b0;
        else
            ffPrev_ff <= timerFlipflopOutput;
    end

    assign ffRise = timerFlipflopOutput & ~ffPrev_ff;
    assign ffFall = ~timerFlipflopOutput & ffPrev_ff;

    // wishbone decode
    assign access = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wrEn = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
    assign wb_ack_o = ack_ff;
    assign swCapture = wrEn & (wb_adr_i == `TMR_OFF_MODE) & wb_sel_i[0]
        & ~wb_dat_i[`TMR_MD_SWCAP];
    assign dbufEn = ctrl_ff[`TMR_CR_DBUF];
    assign counting = state_ff[2];

    always @(posedge clk or posedge rst)
    begin
        if (rst)
            ack_ff <= 1'b0;
        else
            ack_ff <= access;
    end

    // control and mode registers
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_ff <= `TMR_CR_RESET;
            modeLo_ff <= `TMR_MD_LO_RESET;
            cpm_ff <= `TMR_MD_CPM_RESET;
        end
        else if (wrEn && wb_adr_i == `TMR_OFF_CTRL && wb_sel_i[0])
        begin
            ctrl_ff <= wb_dat_i[7:0] & 8'hef;
        end
        else if (wrEn && wb_adr_i == `TMR_OFF_MODE)
        begin
            // mode is meant to change only while stopped
            if (wb_sel_i[0])
                modeLo_ff <= wb_dat_i[7:0] & 8'h8f;
            if (wb_sel_i[1])
                cpm_ff <= wb_dat_i[`TMR_MD_CPM];
        end
    end

    // read mux
    always @*
    begin
        wb_dat_o = 32'h00000000;
        if (ack_ff)
        begin
            case (wb_adr_i)
                `TMR_OFF_CTRL: wb_dat_o = {24'h000000, ctrl_ff};
                `TMR_OFF_MODE: wb_dat_o = {21'h0, cpm_ff,
                    modeLo_ff[7], 1'b1, modeLo_ff[5:0]};
                `TMR_OFF_CNT: wb_dat_o = {16'h0000, cnt_ff};
                `TMR_OFF_CMP0: wb_dat_o = {16'h0000, cmpBuf0_ff};
                `TMR_OFF_CMP1: wb_dat_o = {16'h0000, cmpBuf1_ff};
                `TMR_OFF_CAP0: wb_dat_o = {16'h0000, cap0_ff};
                `TMR_OFF_CAP1: wb_dat_o = {16'h0000, cap1_ff};
                default: wb_dat_o = 32'h00000000;
            endcase
        end
    end

    // start sequencing
    always @*
    begin
        if (ctrl_ff[`TMR_CR_TRIG])
            trigGo = trigFall;
        else
            trigGo = trigRise;
        startGo = (~ctrl_ff[`TMR_CR_START] | trigGo)
            & (~ctrl_ff[`TMR_CR_SYNC] | syncStart);
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
                if (runCmd)
                    nxt_state = startGo ? ST_RUN : ST_WAIT;
            ST_WAIT:
                if (!runCmd)
                    nxt_state = ST_IDLE;
                else if (startGo)
                    nxt_state = ST_RUN;
            ST_RUN:
                if (!runCmd)
                    nxt_state = ST_IDLE;
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
            state_ff <= ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    // source clock select
    always @*
    begin
        case (modeLo_ff[`TMR_MD_CLK])
            `TMR_CLK_PIN: tick = cntRise;
            `TMR_CLK_D1: tick = tap[`TMR_TAP_D1];
            `TMR_CLK_D4: tick = tap[`TMR_TAP_D4];
            `TMR_CLK_D16: tick = tap[`TMR_TAP_D16];
            `TMR_CLK_D64: tick = tap[`TMR_TAP_D64];
            `TMR_CLK_D128: tick = tap[`TMR_TAP_D128];
            `TMR_CLK_D256: tick = tap[`TMR_TAP_D256];
            default: tick = 1'b0;
        endcase
    end

    // capture and pin clear decode
    always @*
    begin
        cap0Go = 1'b0;
        cap1Go = 1'b0;
        pinClear = 1'b0;
        case (cpm_ff)
            `TMR_CPM_OFF:
                cap0Go = 1'b0;
            `TMR_CPM_IN0_IN1:
            begin
                cap0Go = in0Rise;
                cap1Go = in1Rise;
            end
            `TMR_CPM_IN0_BOTH:
            begin
                cap0Go = in0Rise;
                cap1Go = in0Fall;
            end
            `TMR_CPM_FF:
            begin
                cap0Go = ffRise;
                cap1Go = ffFall;
            end
            `TMR_CPM_CLR1:
                pinClear = in1Rise;
            `TMR_CPM_CAP0_CLR1:
            begin
                cap0Go = in0Rise;
                pinClear = in1Rise;
            end
            default:
                pinClear = 1'b0;
        endcase
    end

    assign match0 = counting & tick & (cnt_ff == cmpAct0_ff);
    assign match1 = counting & tick & (cnt_ff == cmpAct1_ff);
    assign cmpClear = match1 & modeLo_ff[`TMR_MD_CLE];

    // up-counter
    always @*
    begin
        nxt_cnt = cnt_ff;
        if (!counting || !runCmd)
            nxt_cnt = `TMR_CNT_ZERO;
        else if (pinClear || cmpClear)
            nxt_cnt = `TMR_CNT_ZERO;
        else if (tick)
            nxt_cnt = cnt_ff + {{(CW-1){1'b0}}, 1'b1};
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
            cnt_ff <= `TMR_CNT_ZERO;
        else
            cnt_ff <= nxt_cnt;
    end

    // capture registers keep the pre-clear count
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cap0_ff <= `TMR_CNT_ZERO;
            cap1_ff <= `TMR_CNT_ZERO;
        end
        else
        begin
            if (cap0Go || swCapture)
                cap0_ff <= cnt_ff;
            if (cap1Go)
                cap1_ff <= cnt_ff;
        end
    end

    // compare registers, buffer then active stage
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cmpBuf0_ff <= `TMR_CNT_ZERO;
            cmpBuf1_ff <= `TMR_CNT_ZERO;
        end
        else if (wrEn && wb_sel_i[1:0] == 2'b11)
        begin
            if (wb_adr_i == `TMR_OFF_CMP0)
                cmpBuf0_ff <= wb_dat_i[CW-1:0];
            if (wb_adr_i == `TMR_OFF_CMP1)
                cmpBuf1_ff <= wb_dat_i[CW-1:0];
        end
    end

    // active stage follows buffer at once, or on a counter clear
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cmpAct0_ff <= `TMR_CNT_ZERO;
            cmpAct1_ff <= `TMR_CNT_ZERO;
        end
        else if (!dbufEn || !counting || cmpClear || pinClear)
        begin
            cmpAct0_ff <= cmpBuf0_ff;
            cmpAct1_ff <= cmpBuf1_ff;
        end
    end

    // registered event outputs
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            countValue <= `TMR_CNT_ZERO;
            compareMatch0 <= 1'b0;
            compareMatch1 <= 1'b0;
            overflowEvent <= 1'b0;
            capture0Event <= 1'b0;
            capture1Event <= 1'b0;
        end
        else
        begin
            countValue <= nxt_cnt;
            compareMatch0 <= match0;
            compareMatch1 <= match1;
            overflowEvent <= counting & tick & ~pinClear & ~cmpClear
                & (&cnt_ff);
            capture0Event <= cap0Go | swCapture;
            capture1Event <= cap1Go;
        end
    end
endmodule // tmr_timer_channel
`default_nettype wire

/* File: verification/tmr_pin_model.sv */
/* tmr_pin_model.sv: drives the count/trigger pin and both capture pins.
   Assumes one clk; each level is held long past the synchroniser. */
`timescale 1ns/1ns
`default_nettype none
module tmr_pin_model (
    // clock
    input wire logic clk,
    // pins toward the channel
    output var logic countPin,
    output var logic cap0Pin,
    output var logic cap1Pin
);
    initial
    begin
        countPin = 1'b0;
        cap0Pin = 1'b0;
        cap1Pin = 1'b0;
    end
    // pin 3 moves both capture inputs in the same cycle
    task automatic set_pin(input int which, input logic v);
        begin
            @(posedge clk);
            case (which)
                0: countPin <= v;
                1: cap0Pin <= v;
                2: cap1Pin <= v;
                default:
                begin
                    cap0Pin <= v;
                    cap1Pin <= v;
                end
            endcase
            repeat (6) @(posedge clk);
        end
    endtask
    task automatic count_pulses(input int n);
        repeat (n)
        begin
            set_pin(0, 1'b1);
            set_pin(0, 1'b0);
        end
    endtask
endmodule // tmr_pin_model
`default_nettype wire

/* File: verification/tmr_timer_channel_props.sv */
/* tmr_timer_channel_props.sv: port assertions of the timer channel.
   Assumes a bind into tmr_timer_channel; rst async, active high. */
`timescale 1ns/1ns
`default_nettype none
module tmr_timer_channel_props #(
    parameter CW = 16
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // bus
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire [31:0] wb_dat_o,
    // counter
    input wire runCmd,
    input wire counting,
    input wire [CW-1:0] countValue
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence reqSeen;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ackPulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    chk_ack_latency: assert property (reqSeen |=> ackPulse)
        else $error("ack not a single pulse after request");
    chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    chk_rdata_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    chk_stop_clears: assert property (
        !runCmd |=> !counting && countValue == '0)
        else $error("stop did not clear counter");
    chk_count_step: assert property (
        counting && $past(counting) |-> countValue == '0 ||
        countValue == $past(countValue) ||
        countValue == $past(countValue) + 1'b1)
        else $error("counter jumped");
    chk_start_cause: assert property ($rose(counting) |-> $past(runCmd))
        else $error("start without run command");
    chk_start_zero: assert property (
        $rose(counting) |-> countValue == '0)
        else $error("count not zero at start");
    chk_idle_zero: assert property (!counting |-> countValue == '0)
        else $error("count moves while stopped");
endmodule // tmr_timer_channel_props
`default_nettype wire

/* File: verification/tmr_timer_channel_tb.sv */
/* tmr_timer_channel_tb.sv: register, start, rate, capture and compare
   tests of the channel. Assumes tmr_pin_model drives the pins. */
`timescale 1ns/1ns
`default_nettype none
`include "tmr_defs.vh"
`define CHECK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tmr_timer_channel_tb;
    logic clk, rst, wbCyc, wbStb, wbWe, wbAck, runCmd, syncStart, ffOut;
    logic countPin, cap0Pin, cap1Pin, counting;
    logic [7:0] wbAdr;
    logic [31:0] wbDatW, wbDatR, rdData;
    logic [3:0] wbSel;
    logic capEv0, capEv1, cmpEv0, cmpEv1;
    int nEv [4] = '{0, 0, 0, 0};
    int snap [4];
    logic [15:0] countValue;
    int failures, comparisons, gap, i;
    logic [2:0] codes [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    int divs [7] = '{1, 4, 16, 0, 64, 128, 256};
    logic [2:0] cpm [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0};
    logic [15:0] e0 [6] = '{16'h3, 16'h3, 16'h5, 16'h5, 16'h1, 16'h1};
    logic [15:0] e1 [6] = '{16'h7, 16'h4, 16'h6, 16'h6, 16'h6, 16'h6};
    logic [15:0] ec [6] = '{16'h8, 16'h8, 16'h8, 16'h1, 16'h0, 16'h8};
    logic db [3] = '{1'b1, 1'b0, 1'b1};
    logic cle [3] = '{1'b1, 1'b1, 1'b0};
    logic [15:0] ecmp [3] = '{16'h1, 16'h5, 16'h5};

    tmr_timer_channel DUT (.clk(clk), .rst(rst), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
        .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
        .runCmd(runCmd), .syncStart(syncStart), .timerFlipflopOutput(ffOut),
        .externalCountInput(countPin), .captureInput0(cap0Pin),
        .captureInput1(cap1Pin), .countValue(countValue),
        .compareMatch0(cmpEv0), .compareMatch1(cmpEv1), .overflowEvent(),
        .capture0Event(capEv0), .capture1Event(capEv1), .counting(counting));
    tmr_pin_model PINS (.clk(clk), .countPin(countPin), .cap0Pin(cap0Pin),
        .cap1Pin(cap1Pin));

    // event pulse counts
    always @(posedge clk)
    begin
        nEv[0] <= nEv[0] + capEv0;
        nEv[1] <= nEv[1] + capEv1;
        nEv[2] <= nEv[2] + cmpEv0;
        nEv[3] <= nEv[3] + cmpEv1;
    end

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        begin
            wbCyc <= 1'b1;
            wbStb <= 1'b1;
            wbWe <= w;
            wbAdr <= a;
            wbDatW <= d;
            do
                @(posedge clk);
            while (wbAck !== 1'b1);
            rdData = wbDatR;
            wbCyc <= 1'b0;
            wbStb <= 1'b0;
            @(posedge clk);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        begin
            xfer(1'b0, a, 32'h0);
            `CHECK(rdData, e)
        end
    endtask
    task automatic run(input logic on);
        begin
            runCmd <= on;
            repeat (3) @(posedge clk);
        end
    endtask
    // cycles until the next counter change, 0 if none
    task automatic tick_gap(output int g);
        logic [15:0] last;
        begin
            g = 0;
            last = countValue;
            for (int k = 1; k <= 600 && g == 0; k++)
            begin
                @(posedge clk);
                if (countValue !== last)
                    g = k;
            end
        end
    endtask
    // pin story: in0 up at 3, down at 4, ff up 5, down 6, in1 up at 7
    task automatic cap_case(input int j);
        begin
            run(1'b0);
            xfer(1'b1, `TMR_OFF_MODE, {21'h0, cpm[j], 8'h40});
            run(1'b1);
            PINS.count_pulses(3);
            PINS.set_pin(1, 1'b1);
            PINS.count_pulses(1);
            PINS.set_pin(1, 1'b0);
            PINS.count_pulses(1);
            ffOut <= 1'b1;
            PINS.count_pulses(1);
            ffOut <= 1'b0;
            PINS.count_pulses(1);
            PINS.set_pin(2, 1'b1);
            PINS.set_pin(2, 1'b0);
            PINS.count_pulses(1);
            if (cpm[j] == `TMR_CPM_CAP0_CLR1)
            begin
                PINS.set_pin(3, 1'b1);
                PINS.set_pin(3, 1'b0);
            end
            rd(`TMR_OFF_CAP0, {16'h0, e0[j]});
            rd(`TMR_OFF_CAP1, {16'h0, e1[j]});
            rd(`TMR_OFF_CNT, {16'h0, ec[j]});
        end
    endtask
    task automatic stop_test();
        begin
            $display("comparisons %0d failures %0d", comparisons, failures);
            if (failures == 0 && comparisons > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask

    initial
    begin
        failures = 0;
        comparisons = 0;
        rst = 1'b1;
        {wbCyc, wbStb, wbWe, runCmd, syncStart, ffOut} = 6'h0;
        wbAdr = 8'h0;
        wbDatW = 32'h0;
        wbSel = 4'hf;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`TMR_OFF_CTRL, 32'h0);
        rd(`TMR_OFF_MODE, 32'h40);
        xfer(1'b1, `TMR_OFF_CTRL, 32'hffffffff);
        rd(`TMR_OFF_CTRL, 32'hef);
        wbSel <= 4'he;
        xfer(1'b1, `TMR_OFF_CTRL, 32'h0);
        wbSel <= 4'hf;
        rd(`TMR_OFF_CTRL, 32'hef);
        xfer(1'b1, `TMR_OFF_MODE, 32'h5ff);
        rd(`TMR_OFF_MODE, 32'h5cf);
        rd(8'h40, 32'h0);
        xfer(1'b1, `TMR_OFF_CTRL, 32'h0);
        for (i = 0; i < 7; i++)
        begin
            xfer(1'b1, `TMR_OFF_MODE, {25'h0, 4'h8, codes[i]});
            run(1'b1);
            tick_gap(gap);
            tick_gap(gap);
            `CHECK(gap, divs[i])
            run(1'b0);
        end
        for (i = 0; i < 2; i++)
        begin
            xfer(1'b1, `TMR_OFF_CTRL, {30'h0, i[0], 1'b1});
            PINS.set_pin(0, ~i[0]);
            run(1'b1);
            PINS.set_pin(0, i[0]);
            `CHECK(counting, 1'b0)
            PINS.set_pin(0, ~i[0]);
            `CHECK(counting, 1'b1)
            run(1'b0);
        end
        xfer(1'b1, `TMR_OFF_CTRL, 32'h20);
        run(1'b1);
        `CHECK(counting, 1'b0)
        syncStart <= 1'b1;
        @(posedge clk);
        syncStart <= 1'b0;
        repeat (3) @(posedge clk);
        `CHECK(counting, 1'b1)
        run(1'b0);
        xfer(1'b1, `TMR_OFF_CTRL, 32'h0);
        snap = nEv;
        for (i = 0; i < 6; i++)
            cap_case(i);
        xfer(1'b1, `TMR_OFF_MODE, 32'h0);
        rd(`TMR_OFF_CAP0, 32'h8);
        `CHECK(nEv[0] - snap[0], 6)
        `CHECK(nEv[1] - snap[1], 3)
        snap = nEv;
        for (i = 0; i < 3; i++)
        begin
            run(1'b0);
            xfer(1'b1, `TMR_OFF_CTRL, {24'h0, db[i], 7'h0});
            xfer(1'b1, `TMR_OFF_MODE, {28'h4, cle[i], 3'h0});
            xfer(1'b1, `TMR_OFF_CMP1, 32'h3);
            run(1'b1);
            xfer(1'b1, `TMR_OFF_CMP1, 32'ha);
            PINS.count_pulses(5);
            rd(`TMR_OFF_CNT, {16'h0, ecmp[i]});
        end
        `CHECK(nEv[2] - snap[2], 4)
        `CHECK(nEv[3] - snap[3], 2)
        stop_test();
    end

    initial
    begin
        repeat (40000) @(posedge clk);
        failures++;
        stop_test();
    end
endmodule // tmr_timer_channel_tb

bind tmr_timer_channel tmr_timer_channel_props #(.CW(CW)) CHK (.clk(clk),
    .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .runCmd(runCmd),
    .counting(counting), .countValue(countValue));
`default_nettype wire
